// *** design/ccr_top.sv ***
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // Reset sources
  input wire logic register_reset,
  input wire logic host_timer_expired,
  // Host timer handshake
  output logic host_timer_restart,
  input wire logic host_timer_restarted,
  // Pins and analog status
  input wire logic charge_enable_pin_n,
  input wire logic [11:0] input_current_limit_ma,
  // Mode controls
  output logic light_load_mode_enable,
  output logic boost_mode_active,
  output logic charge_active,
  output logic source_detect_enable,
  output logic input_switch_high_res,
  // Set points
  output logic [11:0] min_system_voltage_mv,
  output logic [11:0] boost_low_battery_threshold_mv,
  output logic [11:0] boost_low_battery_rise_mv,
  output logic [11:0] fast_charge_current_ma,
  output logic [11:0] precharge_current_ma,
  output logic [11:0] termination_current_ma
);

  ccr_pkg::ccr_top_state_type state;       // All register state
  ccr_pkg::ccr_top_state_type next_state;  // Next register state
  ccr_if link ();                          // Path to the decoder

  // ******************************************************************
  // Register access helper
  // ******************************************************************
  // Restore the timer-restored bits of a register to default
  function automatic logic [7:0] ccr_wd_restore(input logic [7:0] value,
                                                input logic [7:0] dflt,
                                                input logic [7:0] mask);
    ccr_wd_restore = (value & ~mask) | (dflt & mask);
  endfunction : ccr_wd_restore

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    // Timer expiry restores most fields, keeps four
    if (host_timer_expired) begin
      next_state.ctrl1 = ccr_wd_restore(state.ctrl1, `CCR_RST_CTRL1, `CCR_WD_MASK_CTRL1);
      next_state.cur = ccr_wd_restore(state.cur, `CCR_RST_CUR, `CCR_WD_MASK_CUR);
      next_state.pre = ccr_wd_restore(state.pre, `CCR_RST_PRE, `CCR_WD_MASK_PRE);
    end
    // Timer restarted: kick bit returns to 0
    if (host_timer_restarted) begin
      next_state.ctrl1[`CCR_BIT_KICK] = 1'b0;
    end
    // Host write lands after the clears, so a set wins
    if (reg_wr_en) begin
      case (reg_addr)
        `CCR_ADDR_CTRL1: next_state.ctrl1 = reg_wr_data;
        `CCR_ADDR_CUR: next_state.cur = reg_wr_data;
        `CCR_ADDR_PRE: next_state.pre = reg_wr_data;
        default: ;  // Unmapped writes are dropped
      endcase
    end
    // Read answer one cycle later, unmapped reads zero
    if (reg_rd_en) begin
      next_state.rd_valid = 1'b1;
      case (reg_addr)
        `CCR_ADDR_CTRL1: next_state.rd_data = state.ctrl1;
        `CCR_ADDR_CUR: next_state.rd_data = state.cur;
        `CCR_ADDR_PRE: next_state.rd_data = state.pre;
        default: next_state.rd_data = 8'h00;
      endcase
    end
    // Register reset command restores everything
    if (register_reset) begin
      next_state.ctrl1 = `CCR_RST_CTRL1;
      next_state.cur = `CCR_RST_CUR;
      next_state.pre = `CCR_RST_PRE;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{`CCR_RST_CTRL1, `CCR_RST_CUR, `CCR_RST_PRE, 8'h00, 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ******************************************************************
  // Decoder
  // ******************************************************************
  assign link.ctrl1 = state.ctrl1;
  assign link.cur = state.cur;
  assign link.pre = state.pre;

  ccr_decode #(
    .LOWBAT_RISE_ALT_MV (12'haf0)
  ) u_decode (
    .clk (clk),
    .rst_n (rst_n),
    .bus (link.decode)
  );

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign reg_rd_data = state.rd_data;
  assign reg_rd_valid = state.rd_valid;
  assign host_timer_restart = state.ctrl1[`CCR_BIT_KICK];
  assign light_load_mode_enable = ~state.ctrl1[`CCR_BIT_LIGHT_DIS];
  assign boost_mode_active = state.ctrl1[`CCR_BIT_BOOST];
  // Boost wins; code zero also blocks charging
  assign charge_active = state.ctrl1[`CCR_BIT_CHG] & ~charge_enable_pin_n
                         & ~state.ctrl1[`CCR_BIT_BOOST]
                         & (state.cur[`CCR_FAST_CHARGE_CURRENT_HI:0] != 6'h00);
  assign source_detect_enable = state.cur[`CCR_BIT_DETECT];
  assign input_switch_high_res = ~state.cur[`CCR_BIT_FULLON]
                                 & (input_current_limit_ma < `CCR_SWITCH_LIMIT_MA);
  assign min_system_voltage_mv = link.dec.min_sys_mv;
  assign boost_low_battery_threshold_mv = link.dec.lowbat_fall_mv;
  assign boost_low_battery_rise_mv = link.dec.lowbat_rise_mv;
  assign fast_charge_current_ma = link.dec.fast_ma;
  assign precharge_current_ma = link.dec.pre_ma;
  assign termination_current_ma = link.dec.term_ma;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_light;
    light_load_mode_enable == ~reg_rd_data[7] || !$past(reg_rd_en) || $past(reg_addr) != 8'h01
      || $past(reg_wr_en) || $past(register_reset) || $past(host_timer_expired);
  endproperty
  a_light: assert property (p_light) else $error("light load mode mismatch");

  sequence s_kick_write;
    reg_wr_en && reg_addr == 8'h01 && reg_wr_data[6] && !register_reset;
  endsequence
  sequence s_kick_done;
    host_timer_restarted && !reg_wr_en && !register_reset;
  endsequence
  property p_kick;
    s_kick_write ##1 (!reg_wr_en && !register_reset && !host_timer_restarted)
      |-> host_timer_restart;
  endproperty
  a_kick: assert property (p_kick) else $error("timer kick not held");
  property p_kick_clr;
    s_kick_done |=> !host_timer_restart;
  endproperty
  a_kick_clr: assert property (p_kick_clr) else $error("timer kick not cleared");

  property p_boost;
    boost_mode_active |-> !charge_active;
  endproperty
  a_boost: assert property (p_boost) else $error("charging during boost");

  property p_charge;
    charge_active |-> !charge_enable_pin_n && state.ctrl1[4];
  endproperty
  a_charge: assert property (p_charge) else $error("charge without both enables");

  // Register reset outranks every other source, so the defaults always return
  property p_detect;
    register_reset |=> source_detect_enable && state.cur == 8'ha2;
  endproperty
  a_detect: assert property (p_detect) else $error("detection not enabled after reset");

  property p_switch;
    state.cur[6] |-> !input_switch_high_res;
  endproperty
  a_switch: assert property (p_switch) else $error("switch not full on");

  property p_zero;
    state.cur[5:0] == 6'h00 |-> !charge_active;
  endproperty
  a_zero: assert property (p_zero) else $error("charging at zero code");

  property p_expire;
    host_timer_expired && !reg_wr_en && !register_reset
      |=> state.ctrl1[5] == 1'b0 && state.cur[5:0] == 6'h22 && state.pre == 8'h22
          && state.ctrl1[3:0] == $past(state.ctrl1[3:0]) && state.cur[6] == $past(state.cur[6]);
  endproperty
  a_expire: assert property (p_expire) else $error("timer expiry restore wrong");

endmodule : ccr_top

// *** common/ccr_params.svh ***
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define CCR_ADDR_CTRL1 8'h01
`define CCR_ADDR_CUR 8'h02
`define CCR_ADDR_PRE 8'h03

// ********************************************************************
// Reset values and timer-restored bit masks
// ********************************************************************
`define CCR_RST_CTRL1 8'h1a
`define CCR_RST_CUR 8'ha2
`define CCR_RST_PRE 8'h22
`define CCR_WD_MASK_CTRL1 8'h70
`define CCR_WD_MASK_CUR 8'hbf
`define CCR_WD_MASK_PRE 8'hff

// ********************************************************************
// Field positions
// ********************************************************************
`define CCR_BIT_LIGHT_DIS 7
`define CCR_BIT_KICK 6
`define CCR_BIT_BOOST 5
`define CCR_BIT_CHG 4
`define CCR_SYSMIN_HI 3
`define CCR_SYSMIN_LO 1
`define CCR_BIT_LOWBAT 0
`define CCR_BIT_DETECT 7
`define CCR_BIT_FULLON 6
`define CCR_FAST_CHARGE_CURRENT_HI 5
`define CCR_PRE_HI 7
`define CCR_PRE_LO 4
`define CCR_TERM_HI 3

// ********************************************************************
// Analog figures in mA / mV, plus the pre-charge code clamp
// ********************************************************************
`define CCR_STEP_MA 12'h03c
`define CCR_PRE_CLAMP 4'hc
`define CCR_SWITCH_LIMIT_MA 12'h2bc
`define CCR_LOWBAT_FALL_MV 12'hb86
`define CCR_LOWBAT_FALL_ALT_MV 12'ha28
`define CCR_LOWBAT_RISE_MV 12'hc4e

`endif

// *** common/ccr_pkg.sv ***
package ccr_pkg;

  // Register-side state of the top module
  typedef struct packed {
    logic [7:0] ctrl1;    // Control register one
    logic [7:0] cur;      // Charge current limit register
    logic [7:0] pre;      // Pre-charge and termination register
    logic [7:0] rd_data;  // Registered read answer
    logic rd_valid;       // Read answer strobe
  } ccr_top_state_type;

  // Decoded analog set points
  typedef struct packed {
    logic [11:0] min_sys_mv;
    logic [11:0] lowbat_fall_mv;
    logic [11:0] lowbat_rise_mv;
    logic [11:0] fast_ma;
    logic [11:0] pre_ma;
    logic [11:0] term_ma;
  } ccr_dec_state_type;

endpackage : ccr_pkg

// *** common/ccr_if.sv ***
`timescale 1ns/100ps
interface ccr_if;
  // Raw register contents
  logic [7:0] ctrl1;
  logic [7:0] cur;
  logic [7:0] pre;
  // Decoded set points, registered in the decoder
  ccr_pkg::ccr_dec_state_type dec;

  modport regs (output ctrl1, output cur, output pre, input dec);
  modport decode (input ctrl1, input cur, input pre, output dec);
endinterface : ccr_if

// *** design/ccr_decode.sv ***
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_decode #(
  parameter logic [11:0] LOWBAT_RISE_ALT_MV = 12'haf0  // Rising level with 2.6V select
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register contents in, set points out
  ccr_if.decode bus
);

  // ******************************************************************
  // Decode helpers
  // ******************************************************************
  // Offset-plus-step current used by both pre-charge and termination
  function automatic logic [11:0] ccr_step_plus(input logic [3:0] code);
    ccr_step_plus = 12'(`CCR_STEP_MA * ({8'h00, code} + 12'h001));
  endfunction : ccr_step_plus

  // Minimum system voltage table
  function automatic logic [11:0] ccr_sys_mv(input logic [2:0] code);
    case (code)
      3'h0: ccr_sys_mv = 12'ha28;
      3'h1: ccr_sys_mv = 12'haf0;
      3'h2: ccr_sys_mv = 12'hbb8;
      3'h3: ccr_sys_mv = 12'hc80;
      3'h4: ccr_sys_mv = 12'hd48;
      3'h5: ccr_sys_mv = 12'hdac;
      3'h6: ccr_sys_mv = 12'he10;
      default: ccr_sys_mv = 12'he74;
    endcase
  endfunction : ccr_sys_mv

  ccr_pkg::ccr_dec_state_type state;       // Registered set points
  ccr_pkg::ccr_dec_state_type next_state;  // Next set points
  logic [3:0] pre_code;                    // Clamped pre-charge code

  // ******************************************************************
  // Next-state decode
  // ******************************************************************
  always_comb begin
    next_state = state;
    next_state.min_sys_mv = ccr_sys_mv(bus.ctrl1[`CCR_SYSMIN_HI:`CCR_SYSMIN_LO]);
    // Falling threshold from select bit
    if (bus.ctrl1[`CCR_BIT_LOWBAT]) begin
      next_state.lowbat_fall_mv = `CCR_LOWBAT_FALL_ALT_MV;
      next_state.lowbat_rise_mv = LOWBAT_RISE_ALT_MV;
    end else begin
      next_state.lowbat_fall_mv = `CCR_LOWBAT_FALL_MV;
      next_state.lowbat_rise_mv = `CCR_LOWBAT_RISE_MV;
    end
    next_state.fast_ma = 12'(`CCR_STEP_MA * {6'h00, bus.cur[`CCR_FAST_CHARGE_CURRENT_HI:0]});
    // Codes past twelve behave as twelve
    pre_code = bus.pre[`CCR_PRE_HI:`CCR_PRE_LO];
    if (pre_code > `CCR_PRE_CLAMP) begin
      pre_code = `CCR_PRE_CLAMP;
    end
    next_state.pre_ma = ccr_step_plus(pre_code);
    next_state.term_ma = ccr_step_plus(bus.pre[`CCR_TERM_HI:0]);
  end

  // State register, reset matches default register contents
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{12'hdac, 12'hb86, 12'hc4e, 12'h7f8, 12'h0b4, 12'h0b4};
    end else begin
      state <= next_state;
    end
  end

  assign bus.dec = state;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sysmin;
    $past(bus.ctrl1[3:1]) == 3'h5 |-> state.min_sys_mv == 12'hdac;
  endproperty
  a_sysmin: assert property (p_sysmin) else $error("min system voltage wrong");

  property p_lowbat;
    $past(bus.ctrl1[0]) |-> state.lowbat_fall_mv == 12'ha28;
  endproperty
  a_lowbat: assert property (p_lowbat) else $error("low battery threshold wrong");

  property p_fast;
    state.fast_ma == 12'(12'h03c * {6'h00, $past(bus.cur[5:0])});
  endproperty
  a_fast: assert property (p_fast) else $error("fast charge current wrong");

  property p_pre;
    $past(bus.pre[7:4]) <= 4'hc |-> state.pre_ma == 12'(12'h03c + 12'h03c * $past(bus.pre[7:4]));
  endproperty
  a_pre: assert property (p_pre) else $error("pre-charge current wrong");

  property p_clamp;
    $past(bus.pre[7:4]) > 4'hc |-> state.pre_ma == 12'h30c;
  endproperty
  a_clamp: assert property (p_clamp) else $error("pre-charge clamp failed");

  property p_term;
    $past(bus.pre[3:0]) == 4'hf |-> state.term_ma == 12'h3c0;
  endproperty
  a_term: assert property (p_term) else $error("termination current wrong");

endmodule : ccr_decode

// *** tb/ccr_timer_model.sv ***
`timescale 1ns/100ps
module ccr_timer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Kick level and answer delay in cycles
  input wire logic host_timer_restart,
  input wire logic [3:0] answer_delay,
  // Restart acknowledge pulse
  output logic host_timer_restarted
);
  logic [3:0] wait_count;  // Cycles the kick has been seen

  // Answers a standing kick after the chosen delay with a single pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_count <= 4'h0;
      host_timer_restarted <= 1'b0;
    end else if (host_timer_restart && !host_timer_restarted && wait_count >= answer_delay) begin
      host_timer_restarted <= 1'b1;
      wait_count <= 4'h0;
    end else begin
      host_timer_restarted <= 1'b0;
      wait_count <= host_timer_restart ? wait_count + 4'h1 : 4'h0;
    end
  end
endmodule : ccr_timer_model

// *** tb/test_charger_control_registers.sv ***
`timescale 1ns/100ps
module test_charger_control_registers;
  logic clk, rst_n, reg_wr_en, reg_rd_en, register_reset, host_timer_expired;
  logic host_timer_restart, host_timer_restarted, charge_enable_pin_n;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_rd_valid, light_load_mode_enable, boost_mode_active, charge_active;
  logic source_detect_enable, input_switch_high_res;
  logic [11:0] input_current_limit_ma, min_system_voltage_mv, boost_low_battery_threshold_mv;
  logic [11:0] boost_low_battery_rise_mv, fast_charge_current_ma, precharge_current_ma;
  logic [11:0] termination_current_ma;
  logic [3:0] answer_delay;  // Partner answer delay
  int failures, checked, cycles, i, k;
  logic [11:0] sys_tab [8] = '{12'ha28, 12'haf0, 12'hbb8, 12'hc80,
                               12'hd48, 12'hdac, 12'he10, 12'he74};
  logic [5:0] fast_tab [4] = '{6'h00, 6'h01, 6'h22, 6'h3f};

  ccr_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .register_reset(register_reset),
    .host_timer_expired(host_timer_expired), .host_timer_restart(host_timer_restart),
    .host_timer_restarted(host_timer_restarted), .charge_enable_pin_n(charge_enable_pin_n),
    .input_current_limit_ma(input_current_limit_ma),
    .light_load_mode_enable(light_load_mode_enable), .boost_mode_active(boost_mode_active),
    .charge_active(charge_active), .source_detect_enable(source_detect_enable),
    .input_switch_high_res(input_switch_high_res), .min_system_voltage_mv(min_system_voltage_mv),
    .boost_low_battery_threshold_mv(boost_low_battery_threshold_mv),
    .boost_low_battery_rise_mv(boost_low_battery_rise_mv),
    .fast_charge_current_ma(fast_charge_current_ma), .precharge_current_ma(precharge_current_ma),
    .termination_current_ma(termination_current_ma));

  ccr_timer_model partner (.clk(clk), .rst_n(rst_n), .host_timer_restart(host_timer_restart),
    .answer_delay(answer_delay), .host_timer_restarted(host_timer_restarted));

  // ********************************************************************
  // Clock, timeout and shared tasks
  // ********************************************************************
  always #10 clk = ~clk;

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // Compares one value and reports a difference
  task chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One byte write on the register port
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // One byte read, answer checked in its valid cycle
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({11'h000, reg_rd_valid}, 12'h001, "read valid");
    chk({4'h0, reg_rd_data}, {4'h0, exp}, "read data");
  endtask : rd

  // Waits until the decoded set points follow the registers
  task settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Pulses expiry (sel 0) or register reset (sel 1)
  task pulse(input logic sel);
    @(posedge clk);
    if (sel) register_reset <= 1'b1;
    else host_timer_expired <= 1'b1;
    @(posedge clk);
    register_reset <= 1'b0;
    host_timer_expired <= 1'b0;
  endtask : pulse

  // Prints counts and the verdict, then ends the run
  task give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    register_reset = 1'b0;
    host_timer_expired = 1'b0;
    charge_enable_pin_n = 1'b0;
    input_current_limit_ma = 12'h2bc;
    answer_delay = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and decoded defaults
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'ha2);
    rd(8'h03, 8'h22);
    chk({11'h000, light_load_mode_enable}, 12'h001, "light load");
    chk({11'h000, source_detect_enable}, 12'h001, "detect");
    chk(boost_low_battery_rise_mv, 12'hc4e, "rise");
    chk(fast_charge_current_ma, 12'h7f8, "fast default");
    chk(precharge_current_ma, 12'h0b4, "pre default");
    chk(termination_current_ma, 12'h0b4, "term default");
    // Unmapped place reads zero and ignores writes
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    $display("test reset done");
    // Minimum system voltage table
    for (i = 0; i < 8; i++) begin
      wr(8'h01, 8'h10 | 8'(i << 1));
      settle();
      chk(min_system_voltage_mv, sys_tab[i], "min_system_voltage_sel");
    end
    // Fast charge codes, zero disables charging
    for (i = 0; i < 4; i++) begin
      wr(8'h02, {2'b10, fast_tab[i]});
      settle();
      chk(fast_charge_current_ma, 12'(60 * fast_tab[i]), "fast");
      chk({11'h000, charge_active}, 12'(fast_tab[i] != 6'h00), "fast zero");
    end
    // Pre-charge clamp and termination steps
    for (i = 0; i < 16; i++) begin
      wr(8'h03, {4'(i), 4'(i)});
      settle();
      chk(precharge_current_ma, 12'(60 + 60 * (i > 12 ? 12 : i)), "pre");
      chk(termination_current_ma, 12'(60 + 60 * i), "term");
    end
    $display("test decode done");
    // Mode bits, boost priority and enable pin
    wr(8'h01, 8'hb1);
    settle();
    chk({11'h000, light_load_mode_enable}, 12'h000, "light off");
    chk({11'h000, boost_mode_active}, 12'h001, "boost");
    chk({11'h000, charge_active}, 12'h000, "boost priority");
    chk(boost_low_battery_threshold_mv, 12'ha28, "lowbat alt");
    chk(boost_low_battery_rise_mv, 12'haf0, "rise alt");
    wr(8'h01, 8'h1a);
    settle();
    chk(boost_low_battery_threshold_mv, 12'hb86, "lowbat");
    chk({11'h000, charge_active}, 12'h001, "charge on");
    @(posedge clk);
    charge_enable_pin_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({11'h000, charge_active}, 12'h000, "pin high");
    wr(8'h01, 8'h0a);
    charge_enable_pin_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({11'h000, charge_active}, 12'h000, "bit off");
    // Source detection and input switch
    wr(8'h02, 8'h22);
    input_current_limit_ma <= 12'h2bb;
    @(posedge clk);
    #1;
    chk({11'h000, source_detect_enable}, 12'h000, "detect off");
    chk({11'h000, input_switch_high_res}, 12'h001, "switch 699");
    @(posedge clk);
    input_current_limit_ma <= 12'h2bc;
    @(posedge clk);
    #1;
    chk({11'h000, input_switch_high_res}, 12'h000, "switch 700");
    wr(8'h02, 8'h62);
    input_current_limit_ma <= 12'h258;
    @(posedge clk);
    #1;
    chk({11'h000, input_switch_high_res}, 12'h000, "full on");
    $display("test modes done");
    // Timer kick, prompt and slow partner
    for (i = 0; i < 2; i++) begin
      answer_delay <= i ? 4'h6 : 4'h0;
      wr(8'h01, 8'h5a);
      #1;
      chk({11'h000, host_timer_restart}, 12'h001, "kick");
      for (k = 0; k < 20 && host_timer_restart !== 1'b0; k++) @(posedge clk);
      #1;
      chk({11'h000, host_timer_restart}, 12'h000, "kick clear");
      rd(8'h01, 8'h1a);
    end
    // Expiry keeps four fields, register reset restores all
    wr(8'h01, 8'hb7);
    wr(8'h02, 8'h40);
    wr(8'h03, 8'h55);
    pulse(1'b0);
    rd(8'h01, 8'h97);
    rd(8'h02, 8'he2);
    rd(8'h03, 8'h22);
    pulse(1'b1);
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'ha2);
    $display("test timer done");
    give_verdict();
  end
endmodule : test_charger_control_registers
